// File: verilog/scan_tap_pkg.sv
package scan_tap_pkg;

  // ---------------------------------------------------------------------------
  // Register widths and instruction codes
  // ---------------------------------------------------------------------------
  localparam int INSTR_W    = 3;
  localparam int ID_W       = 32;
  localparam int CHAIN_W    = 109;
  localparam int TLR_ONES   = 5;
  localparam int SYNC_W     = 2;

  localparam logic [2:0] OP_EXT_TEST = 3'h0;
  localparam logic [2:0] OP_IDENT    = 3'h1;
  localparam logic [2:0] OP_SAMPLE_Z = 3'h2;
  localparam logic [2:0] OP_PRELOAD  = 3'h4;
  localparam logic [2:0] OP_BYPASS   = 3'h7;

  // Capture-IR pattern: low two bits are 01.
  localparam logic [2:0] IR_CAPTURE  = 3'h1;

  // Arbitrary identification value, not that of any real part.
  localparam logic [31:0] ID_VALUE_DEFAULT = 32'h0000_0001;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_PS     = 8000;
  localparam int TDO_VALID_MAX_NS  = 20;
  localparam int TDO_VALID_CYC     = (TDO_VALID_MAX_NS * 1000) / CLK_PERIOD_PS;

  typedef enum logic [3:0] {
    ST_RESET      = 4'b0000,
    ST_IDLE       = 4'b0001,
    ST_SEL_DR     = 4'b0010,
    ST_CAP_DR     = 4'b0011,
    ST_SHIFT_DR   = 4'b0100,
    ST_EXIT1_DR   = 4'b0101,
    ST_PAUSE_DR   = 4'b0110,
    ST_EXIT2_DR   = 4'b0111,
    ST_UPD_DR     = 4'b1000,
    ST_SEL_IR     = 4'b1001,
    ST_CAP_IR     = 4'b1010,
    ST_SHIFT_IR   = 4'b1011,
    ST_EXIT1_IR   = 4'b1100,
    ST_PAUSE_IR   = 4'b1101,
    ST_EXIT2_IR   = 4'b1110,
    ST_UPD_IR     = 4'b1111
  } tap_state_t;

  // Serial pins, already synchronised.
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } scan_pins_t;

  // One shifted-in boundary word travelling to the update stage.
  typedef struct packed {
    logic [CHAIN_W-1:0] bits;
  } chain_word_t;

endpackage

// File: verilog/scan_word_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module scan_word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push, pop;

  always_comb begin
    push  = in_valid && (cnt_q != (AW+1)'(DEPTH));
    pop   = out_ready && (cnt_q != '0);
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
    end
    if (pop) begin
      rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
    end
    if (push && !pop) begin
      cnt_d = cnt_q + (AW+1)'(1);
    end else if (pop && !push) begin
      cnt_d = cnt_q - (AW+1)'(1);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
endmodule
`default_nettype wire

// File: verilog/sram_boundary_scan_tap.sv
`timescale 1ns/10ps
`default_nettype none
// Operation
// R1: EXTEST drives chain onto outputs, captures inputs.
// R2: EXTEST at Update-IR enables drivers, drives preload.
// R3: Controller preloads first vector before EXTEST.
// R4: Output register contents undefined during EXTEST.
// R5: System reapplies power-up after EXTEST.
// R6: IDCODE captures fixed value, shifts 32 bits.
// R7: IDCODE loaded at power-up and Test-Logic-Reset.
// R8: SAMPLE-Z forces all memory outputs high-Z.
// R9: SAMPLE-Z captures input pins, shifts 109-bit chain.
// R10: Clock recovery needed after leaving SAMPLE-Z.
// R11: Reserved codes 011, 101, 110 never loaded.
// R12: SAMPLE/PRELOAD captures pins, shifts chain.
// R13: Capturing changing pins is harmless, maybe unrepeatable.
// R14: BYPASS gives one-bit path.
// R15: Pins stable across capture window.
// R16: Inputs on rising edge, output on falling.
// R17: Five TMS highs force Test-Logic-Reset.
// R18: Controller reset at power-up.
// R19: Undriven TDI and TMS read as one.
// R20: Sixteen-state controller, LSB-first shifting.
// R21: Capture-IR loads pattern ending 01.
module sram_boundary_scan_tap
  import scan_tap_pkg::*;
#(
  parameter logic [ID_W-1:0] ID_VALUE = ID_VALUE_DEFAULT,
  parameter int              FIFO_DEPTH = 4
) (
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic               tck,
  input  wire logic               tms,
  input  wire logic               tms_drv,
  input  wire logic               tdi,
  input  wire logic               tdi_drv,
  output logic                    tdo,
  output logic                    tdo_oe,
  input  wire logic [CHAIN_W-1:0] pin_state,
  output logic      [CHAIN_W-1:0] pin_drive,
  output logic                    pin_test_oe,
  output logic                    mem_out_hiz,
  output logic                    mem_out_corrupt
);

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  // The drive-sense inputs are synchronised beside their pins and combined
  // only afterwards, so no gate ever reads a pin that has not been flopped.
  logic [4:0]         sync1_q, sync2_q;
  logic               tck_s, tms_s, tms_drv_s, tdi_s, tdi_drv_s;
  logic               tck_prev_q;
  logic [CHAIN_W-1:0] cap1_q, cap2_q;
  scan_pins_t         pins;

  // Undriven test pins count as one, so a floating pin cannot walk the
  // controller out of reset.
  always_comb begin
    {tck_s, tms_s, tms_drv_s, tdi_s, tdi_drv_s} = sync2_q;
    pins.tck = tck_s;
    pins.tms = tms_s | ~tms_drv_s; // [R19]
    pins.tdi = tdi_s | ~tdi_drv_s; // [R19]
  end

  // Boundary pins are asynchronous to this clock; double flopping only bounds
  // metastability, a changing pin may still give a different value each run.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_q    <= '0;
      sync2_q    <= '0;
      tck_prev_q <= 1'b0;
      cap1_q     <= '0;
      cap2_q     <= '0;
    end else begin
      sync1_q    <= {tck, tms, tms_drv, tdi, tdi_drv};
      sync2_q    <= sync1_q;
      tck_prev_q <= pins.tck;
      cap1_q     <= pin_state; // [R13]
      cap2_q     <= cap1_q;
    end
  end

  logic tck_rise, tck_fall;
  always_comb begin
    tck_rise = pins.tck & ~tck_prev_q; // [R16]
    tck_fall = ~pins.tck & tck_prev_q; // [R16]
  end

  // ---------------------------------------------------------------------------
  // Controller
  // ---------------------------------------------------------------------------
  tap_state_t st_q, st_d;

  // The test clock is oversampled, so each of its phases must last more than
  // one system clock; a shorter phase can fall between samples and lose an edge,
  // and the controller falls out of step with the host.

  always_comb begin
    st_d = st_q;
    if (tck_rise) begin
      case (st_q) // [R20] [R17]
        ST_RESET:    st_d = pins.tms ? ST_RESET    : ST_IDLE;
        ST_IDLE:     st_d = pins.tms ? ST_SEL_DR   : ST_IDLE;
        ST_SEL_DR:   st_d = pins.tms ? ST_SEL_IR   : ST_CAP_DR;
        ST_CAP_DR:   st_d = pins.tms ? ST_EXIT1_DR : ST_SHIFT_DR;
        ST_SHIFT_DR: st_d = pins.tms ? ST_EXIT1_DR : ST_SHIFT_DR;
        ST_EXIT1_DR: st_d = pins.tms ? ST_UPD_DR   : ST_PAUSE_DR;
        ST_PAUSE_DR: st_d = pins.tms ? ST_EXIT2_DR : ST_PAUSE_DR;
        ST_EXIT2_DR: st_d = pins.tms ? ST_UPD_DR   : ST_SHIFT_DR;
        ST_UPD_DR:   st_d = pins.tms ? ST_SEL_DR   : ST_IDLE;
        ST_SEL_IR:   st_d = pins.tms ? ST_RESET    : ST_CAP_IR;
        ST_CAP_IR:   st_d = pins.tms ? ST_EXIT1_IR : ST_SHIFT_IR;
        ST_SHIFT_IR: st_d = pins.tms ? ST_EXIT1_IR : ST_SHIFT_IR;
        ST_EXIT1_IR: st_d = pins.tms ? ST_UPD_IR   : ST_PAUSE_IR;
        ST_PAUSE_IR: st_d = pins.tms ? ST_EXIT2_IR : ST_PAUSE_IR;
        ST_EXIT2_IR: st_d = pins.tms ? ST_UPD_IR   : ST_SHIFT_IR;
        ST_UPD_IR:   st_d = pins.tms ? ST_SEL_DR   : ST_IDLE;
        default:     st_d = ST_RESET;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= ST_RESET; // [R18]
    end else begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Scan registers
  // ---------------------------------------------------------------------------
  logic [INSTR_W-1:0] instr_reg_q, instr_reg_d;
  logic [INSTR_W-1:0] ir_shift_q, ir_shift_d;
  logic               bypass_bit_reg_q, bypass_bit_reg_d;
  logic [ID_W-1:0]    maker_part_code_chain_q, maker_part_code_chain_d;
  logic [CHAIN_W-1:0] boundary_chain_q, boundary_chain_d;
  logic               is_ext_test, is_ident, is_sample_z, sel_chain;

  // Reserved codes raise none of these flags and so fall through to the
  // bypass path; a stray code then costs one stage and nothing else.
  always_comb begin
    is_ext_test = (instr_reg_q == OP_EXT_TEST);
    is_ident    = (instr_reg_q == OP_IDENT);
    is_sample_z = (instr_reg_q == OP_SAMPLE_Z);
    sel_chain   = is_ext_test || is_sample_z || (instr_reg_q == OP_PRELOAD);
  end

  // Both update states act on the rising tck edge that leaves them, so the
  // new instruction or vector has settled before the next shift begins.
  always_comb begin
    instr_reg_d             = instr_reg_q;
    ir_shift_d              = ir_shift_q;
    bypass_bit_reg_d        = bypass_bit_reg_q;
    maker_part_code_chain_d = maker_part_code_chain_q;
    boundary_chain_d        = boundary_chain_q;
    if (st_q == ST_RESET) begin
      instr_reg_d = OP_IDENT; // [R7]
    end
    if (tck_rise) begin
      case (st_q)
        ST_CAP_IR: ir_shift_d = IR_CAPTURE; // [R21]
        ST_SHIFT_IR: ir_shift_d = {pins.tdi, ir_shift_q[INSTR_W-1:1]}; // [R20]
        ST_UPD_IR: instr_reg_d = ir_shift_q; // [R2]
        ST_CAP_DR: begin
          bypass_bit_reg_d = 1'b0;
          if (instr_reg_q == OP_IDENT) begin
            maker_part_code_chain_d = ID_VALUE; // [R6]
          end
          if (sel_chain) begin
            boundary_chain_d = cap2_q; // [R1] [R9] [R12]
          end
        end
        ST_SHIFT_DR: begin
          bypass_bit_reg_d = pins.tdi; // [R14]
          if (instr_reg_q == OP_IDENT) begin
            maker_part_code_chain_d = {pins.tdi, maker_part_code_chain_q[ID_W-1:1]}; // [R6]
          end
          if (sel_chain) begin
            boundary_chain_d = {pins.tdi, boundary_chain_q[CHAIN_W-1:1]}; // [R9] [R12]
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      instr_reg_q             <= OP_IDENT; // [R7]
      ir_shift_q              <= '0;
      bypass_bit_reg_q        <= 1'b0;
      maker_part_code_chain_q <= '0;
      boundary_chain_q        <= '0;
    end else begin
      instr_reg_q             <= instr_reg_d;
      ir_shift_q              <= ir_shift_d;
      bypass_bit_reg_q        <= bypass_bit_reg_d;
      maker_part_code_chain_q <= maker_part_code_chain_d;
      boundary_chain_q        <= boundary_chain_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Update stage through the word buffer
  // ---------------------------------------------------------------------------
  // Update-DR pushes the chain into a small buffer that drains into the
  // drive latch one word per clock. A push that meets a full buffer is
  // dropped; at any legal test-clock rate the buffer is empty again long
  // before the next Update-DR, so this cannot happen in practice.
  chain_word_t fifo_in, fifo_out;
  logic        push_req, fifo_ready, fifo_valid;

  always_comb begin
    fifo_in.bits = boundary_chain_q;
    push_req = tck_rise && (st_q == ST_UPD_DR) && sel_chain && fifo_ready;
  end

  scan_word_fifo #(
    .WIDTH ($bits(chain_word_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (push_req),
    .in_ready  (fifo_ready),
    .in_data   (fifo_in),
    .out_valid (fifo_valid),
    .out_ready (1'b1),
    .out_data  (fifo_out)
  );

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  logic [CHAIN_W-1:0] drive_q, drive_d;
  logic tdo_q, tdo_d, tdo_oe_q, tdo_oe_d;
  logic test_oe_q, test_oe_d, hiz_q, hiz_d, corrupt_q, corrupt_d;
  logic shift_out;

  // Serial output source. The tdo flop trails the falling tck edge by up to
  // three system clocks, which a host at a fast test clock must allow for by
  // sampling late in the low phase.
  always_comb begin
    if (st_q == ST_SHIFT_IR) begin
      shift_out = ir_shift_q[0];
    end else if (is_ident) begin
      shift_out = maker_part_code_chain_q[0];
    end else if (sel_chain) begin
      shift_out = boundary_chain_q[0];
    end else begin
      shift_out = bypass_bit_reg_q; // [R14]
    end
  end

  always_comb begin
    drive_d   = drive_q;
    tdo_d     = tdo_q;
    tdo_oe_d  = tdo_oe_q;
    if (fifo_valid) begin
      drive_d = fifo_out.bits; // [R2]
    end
    if (tck_fall) begin
      tdo_oe_d = (st_q == ST_SHIFT_DR) || (st_q == ST_SHIFT_IR); // [R16]
      tdo_d    = shift_out; // [R16]
    end
    test_oe_d = is_ext_test; // [R1] [R2]
    hiz_d     = is_sample_z || is_ext_test; // [R8]
    corrupt_d = is_ext_test; // [R4]
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      drive_q   <= '0;
      tdo_q     <= 1'b0;
      tdo_oe_q  <= 1'b0;
      test_oe_q <= 1'b0;
      hiz_q     <= 1'b0;
      corrupt_q <= 1'b0;
    end else begin
      drive_q   <= drive_d;
      tdo_q     <= tdo_d;
      tdo_oe_q  <= tdo_oe_d;
      test_oe_q <= test_oe_d;
      hiz_q     <= hiz_d;
      corrupt_q <= corrupt_d;
    end
  end

  assign tdo             = tdo_q;
  assign tdo_oe          = tdo_oe_q;
  assign pin_drive       = drive_q;
  assign pin_test_oe     = test_oe_q;
  assign mem_out_hiz     = hiz_q;
  assign mem_out_corrupt = corrupt_q;

endmodule
`default_nettype wire

// File: test/tap_properties.sv
`timescale 1ns/10ps
`default_nettype none
module tap_properties
  import scan_tap_pkg::*;
(
  input wire logic               clk,
  input wire logic               sys_rst,
  input wire logic               tck,
  input wire logic               tms,
  input wire logic               tms_drv,
  input wire logic               tdo,
  input wire logic               tdo_oe,
  input wire logic [CHAIN_W-1:0] pin_drive,
  input wire logic               pin_test_oe,
  input wire logic               mem_out_hiz,
  input wire logic               mem_out_corrupt
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic       tck_q;
  logic [2:0] ones_q;
  logic [2:0] ones_d;
  // An undriven mode pin reads as one, so it counts toward the reset run.
  always_comb begin
    ones_d = ones_q;
    if (tck && !tck_q) begin
      ones_d = (tms || !tms_drv) ? ((ones_q == 3'h5) ? ones_q : ones_q + 3'h1) : 3'h0;
    end
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tck_q  <= 1'b0;
      ones_q <= 3'h0;
    end else begin
      tck_q  <= tck;
      ones_q <= ones_d;
    end
  end
  sequence ident_mode;
    !pin_test_oe && !mem_out_hiz && !mem_out_corrupt;
  endsequence
  reset_quiet_a: assert property (disable iff (1'b0) (sys_rst && $past(sys_rst)) |-> !tdo_oe ##0 ident_mode)
    else $error("test outputs active in reset");
  five_ones_a: assert property (ones_q == 3'h5 |-> ##[0:8] ident_mode)
    else $error("mode highs did not restore identification");
  ext_lock_a: assert property (pin_test_oe |-> ##[0:1] (mem_out_corrupt && mem_out_hiz))
    else $error("external test without output lockout");
  corrupt_ext_a: assert property (mem_out_corrupt |-> ##[0:1] pin_test_oe)
    else $error("corrupt flag without external test");
  tdo_fall_a: assert property ($changed(tdo) |-> !tck && !$past(tck, 2))
    else $error("tdo moved outside tck low");
  oe_hold_a: assert property ($rose(tdo_oe) |-> !tck ##1 tdo_oe [*8])
    else $error("tdo enable glitch");
  mode_rise_a: assert property ($changed({pin_test_oe, mem_out_hiz}) |-> tck && $past(tck, 4))
    else $error("mode outputs moved outside tck high");
  drive_rise_a: assert property ($changed(pin_drive) |-> tck && $past(tck, 3))
    else $error("pin drive moved outside tck high");
endmodule
`default_nettype wire

// File: test/jtag_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module jtag_host_model
  import scan_tap_pkg::*;
(
  output logic     tck,
  output logic     tms,
  output logic     tms_drv,
  output logic     tdi,
  output logic     tdi_drv,
  input wire logic tdo
);
  // The test clock idles low between transfers and never runs free.
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tms_drv = 1'b0;
    tdi = 1'b1;
    tdi_drv = 1'b0;
  end
  // Edges sit 2 ns off the system grid so no sample races them.
  task automatic step(input logic m, input logic d, output logic o);
    #2;
    tms = m;
    tms_drv = 1'b1;
    tdi = d;
    tdi_drv = 1'b1;
    #76 o = tdo;
    tck = 1'b1;
    #80 tck = 1'b0;
    #2;
  endtask
  // Released pins toggle, so a stale level can never pass for a one.
  task automatic idle_pins(input int n);
    repeat (n) begin
      #2;
      tms_drv = 1'b0;
      tdi_drv = 1'b0;
      tms = !tms;
      tdi = !tdi;
      #76 tck = 1'b1;
      #80 tck = 1'b0;
      #2;
    end
  endtask
  task automatic shift(input int n, input logic [CHAIN_W-1:0] din,
                       output logic [CHAIN_W-1:0] dout);
    logic o;
    dout = '0;
    for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
    step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
  endtask
  task automatic scan_dr(input int n, input logic [CHAIN_W-1:0] din,
                         output logic [CHAIN_W-1:0] dout);
    logic o;
    for (int i = 0; i < 3; i++) step(i == 0, 1'b1, o);
    shift(n, din, dout);
  endtask
  task automatic load_ir(input logic [2:0] code, output logic [CHAIN_W-1:0] cap);
    logic o;
    for (int i = 0; i < 4; i++) step(i < 2, 1'b1, o);
    shift(INSTR_W, CHAIN_W'(code), cap);
  endtask
endmodule
`default_nettype wire

// File: test/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench
  import scan_tap_pkg::*;
;
  localparam logic [CHAIN_W-1:0] P1 = {{27{4'h9}}, 1'h1};
  localparam logic [CHAIN_W-1:0] P2 = {{27{4'h6}}, 1'h0};
  localparam logic [CHAIN_W-1:0] D1 = {{27{4'h3}}, 1'h0};
  localparam logic [CHAIN_W-1:0] D2 = {{27{4'ha}}, 1'h1};
  localparam logic [2:0]         OPS [2] = '{OP_BYPASS, OP_BYPASS};
  logic               clk, sys_rst, tck, tms, tms_drv, tdi, tdi_drv, tdo, tdo_oe, bit_o;
  logic               pin_test_oe, mem_out_hiz, mem_out_corrupt;
  logic [CHAIN_W-1:0] pin_state, pin_drive, got;
  int                 err_total, comparisons;
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  sram_boundary_scan_tap DUT (
    .clk(clk), .sys_rst(sys_rst), .tck(tck), .tms(tms), .tms_drv(tms_drv),
    .tdi(tdi), .tdi_drv(tdi_drv), .tdo(tdo), .tdo_oe(tdo_oe), .pin_state(pin_state),
    .pin_drive(pin_drive), .pin_test_oe(pin_test_oe), .mem_out_hiz(mem_out_hiz),
    .mem_out_corrupt(mem_out_corrupt)
  );
  jtag_host_model host (
    .tck(tck), .tms(tms), .tms_drv(tms_drv), .tdi(tdi), .tdi_drv(tdi_drv), .tdo(tdo)
  );
  function automatic logic [CHAIN_W-1:0] modes();
    return CHAIN_W'({pin_test_oe, mem_out_hiz, mem_out_corrupt});
  endfunction
  task automatic chk(input string name, input logic [CHAIN_W-1:0] exp,
                     input logic [CHAIN_W-1:0] act);
    comparisons++;
    if (act !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", name, exp, act);
    end
  endtask
  task automatic stop_test();
    $display("%0d comparisons, %0d mismatches", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic do_reset();
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic read_ident(input string name);
    host.step(1'b0, 1'b1, bit_o);
    host.scan_dr(ID_W, '0, got);
    chk(name, CHAIN_W'(ID_VALUE_DEFAULT), got);
  endtask
  initial begin
    sys_rst = 1'b1;
    pin_state = '0;
    err_total = 0;
    comparisons = 0;
    do_reset();
    read_ident("power-up ident");
    $display("identification test done");
    foreach (OPS[i]) begin
      host.load_ir(OPS[i], got);
      chk("ir capture", CHAIN_W'(IR_CAPTURE), got);
      host.scan_dr(4, CHAIN_W'(4'hb), got);
      chk("one-stage path", CHAIN_W'(4'h6), got);
      chk("bypass modes", '0, modes());
    end
    $display("bypass test done");
    @(posedge clk) pin_state <= P1;
    host.load_ir(OP_PRELOAD, got);
    host.scan_dr(CHAIN_W, D1, got);
    chk("sample capture", P1, got);
    host.load_ir(OP_EXT_TEST, got);
    chk("preload on pins", D1, pin_drive);
    chk("extest modes", CHAIN_W'(3'h7), modes());
    @(posedge clk) pin_state <= P2;
    host.scan_dr(CHAIN_W, D2, got);
    chk("extest capture", P2, got);
    chk("extest pins", D2, pin_drive);
    $display("boundary test done");
    do_reset();
    chk("reset modes", '0, modes());
    read_ident("ident after reset");
    @(posedge clk) pin_state <= ~P1;
    host.load_ir(OP_SAMPLE_Z, got);
    chk("sample-z modes", CHAIN_W'(3'h2), modes());
    host.scan_dr(CHAIN_W, D1, got);
    chk("sample-z capture", ~P1, got);
    host.idle_pins(5);
    chk("floating reset modes", '0, modes());
    read_ident("ident after floating reset");
    $display("high-impedance test done");
    do_reset();
    chk("recovered modes", '0, modes());
    $display("recovery test done");
    stop_test();
  end
  initial begin
    #200000;
    err_total++;
    $display("watchdog expired");
    stop_test();
  end
endmodule
bind sram_boundary_scan_tap tap_properties props (
  .clk(clk), .sys_rst(sys_rst), .tck(tck), .tms(tms), .tms_drv(tms_drv), .tdo(tdo),
  .tdo_oe(tdo_oe), .pin_drive(pin_drive), .pin_test_oe(pin_test_oe),
  .mem_out_hiz(mem_out_hiz), .mem_out_corrupt(mem_out_corrupt)
);
`default_nettype wire
